// ===== kmw_dev.sv
`timescale 1ns/1ns
`include "kmw_params.svh"

module kmw_dev
  import kmw_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic stby_rst,
  input wire logic main_pwr_ok,
  input wire logic kbd_data_line,
  input wire logic kbd_clock_line,
  input wire logic mouse_data_line,
  input wire logic mouse_clock_line,
  input wire logic core_kbd_irq_raw,
  input wire logic core_mouse_irq_raw,
  input wire logic core_kbd_obuf_read,
  input wire logic core_mouse_obuf_read,
  output logic core_kbd_data,
  output logic core_kbd_clock,
  output logic core_mouse_data,
  output logic core_mouse_clock,
  output logic core_reset,
  kmw_cfg_if.dev bus
);

  // ==========================================================
  // pin synchronisers
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [4:0] pin_raw;

  assign pin_raw = {main_pwr_ok, mouse_clock_line, mouse_data_line,
                    kbd_clock_line, kbd_data_line};

  // two stages, only the second is looked at
  always_ff @(posedge clk)
  begin
    pin_s1_q <= pin_raw;
    pin_s2_q <= pin_s1_q;
  end

  wire kbd_data_line_s = pin_s2_q[0];
  wire kbd_clock_line_s = pin_s2_q[1];
  wire mouse_data_line_s = pin_s2_q[2];
  wire mclk_s = pin_s2_q[3];
  wire pwr_s = pin_s2_q[4];

  // ==========================================================
  // configuration registers
  kmw_byte_t core_rst_q;
  kmw_byte_t option_lo_q;
  logic k_iso_q;
  logic m_iso_q;
  kmw_byte_t wake_en_q;
  logic sts_kbd_q;
  logic sts_mouse_q;
  kmw_byte_t rdata_q;

  wire wr_core_rst = bus.cfg_wr && bus.cfg_addr == `KMW_OFS_CORE_RST;
  wire wr_option = bus.cfg_wr && bus.cfg_addr == `KMW_OFS_OPTION;
  wire wr_sts = bus.cfg_wr && bus.cfg_addr == `KMW_OFS_WAKE_STS;
  wire wr_en = bus.cfg_wr && bus.cfg_addr == `KMW_OFS_WAKE_EN;

  wire mouse_irq_latch_sel_sel = option_lo_q[`KMW_BIT_MOUSE_IRQ_LATCH_SEL];
  wire kbd_irq_latch_sel_sel = option_lo_q[`KMW_BIT_KBD_IRQ_LATCH_SEL];

  // main-domain bits, cleared on every main reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      core_rst_q <= `KMW_RST_BYTE;
      option_lo_q <= `KMW_RST_BYTE;
    end
    else
    begin
      if (wr_core_rst)
        core_rst_q <= bus.cfg_wdata;
      if (wr_option)
        option_lo_q <= bus.cfg_wdata & ~`KMW_ISO_MASK;
    end
  end

  assign core_reset = core_rst_q[`KMW_BIT_CORE_RST];

  // standby-domain bits survive main resets
  always_ff @(posedge clk)
  begin
    if (stby_rst)
    begin
      k_iso_q <= 1'b0;
      m_iso_q <= 1'b0;
      wake_en_q <= `KMW_RST_BYTE;
    end
    else
    begin
      if (wr_option)
      begin
        k_iso_q <= bus.cfg_wdata[`KMW_BIT_K_ISO];
        m_iso_q <= bus.cfg_wdata[`KMW_BIT_M_ISO];
      end
      if (wr_en)
        wake_en_q <= bus.cfg_wdata;
    end
  end

  // ==========================================================
  // interrupt latches
  logic kraw_prev_q;
  logic mraw_prev_q;
  logic klat_q;
  logic mlat_q;

  wire krise = core_kbd_irq_raw && !kraw_prev_q;
  wire mrise = core_mouse_irq_raw && !mraw_prev_q;

  // a new rise beats a read in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      kraw_prev_q <= 1'b0;
      mraw_prev_q <= 1'b0;
      klat_q <= 1'b0;
      mlat_q <= 1'b0;
    end
    else
    begin
      kraw_prev_q <= core_kbd_irq_raw;
      mraw_prev_q <= core_mouse_irq_raw;
      klat_q <= krise || (klat_q && !core_kbd_obuf_read);
      mlat_q <= mrise || (mlat_q && !core_mouse_obuf_read);
    end
  end

  wire kirq_d = kbd_irq_latch_sel_sel ? klat_q : (core_kbd_irq_raw && klat_q);
  wire mirq_d = mouse_irq_latch_sel_sel ? mlat_q : (core_mouse_irq_raw && mlat_q);

  // ==========================================================
  // isolation gates toward the core
  logic kirq_q;
  logic mirq_q;
  logic kbd_data_line_q;
  logic kbd_clock_line_q;
  logic mouse_data_line_q;
  logic mclk_q;

  // blocked lines idle high so the core sees a quiet bus
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      kirq_q <= 1'b0;
      mirq_q <= 1'b0;
      kbd_data_line_q <= `KMW_LINE_IDLE;
      kbd_clock_line_q <= `KMW_LINE_IDLE;
      mouse_data_line_q <= `KMW_LINE_IDLE;
      mclk_q <= `KMW_LINE_IDLE;
    end
    else
    begin
      kirq_q <= kirq_d;
      mirq_q <= mirq_d;
      kbd_data_line_q <= k_iso_q ? `KMW_LINE_IDLE : kbd_data_line_s;
      kbd_clock_line_q <= k_iso_q ? `KMW_LINE_IDLE : kbd_clock_line_s;
      mouse_data_line_q <= m_iso_q ? `KMW_LINE_IDLE : mouse_data_line_s;
      mclk_q <= m_iso_q ? `KMW_LINE_IDLE : mclk_s;
    end
  end

  assign core_kbd_data = kbd_data_line_q;
  assign core_kbd_clock = kbd_clock_line_q;
  assign core_mouse_data = mouse_data_line_q;
  assign core_mouse_clock = mclk_q;
  assign bus.kbd_irq = kirq_q;
  assign bus.mouse_irq = mirq_q;

  // ==========================================================
  // wake event detection
  logic kbd_data_line_prev_q;
  logic mouse_data_line_prev_q;

  // previous level starts high: a line already low after standby
  // reset counts as an edge, so a peripheral powering up is seen
  always_ff @(posedge clk)
  begin
    if (stby_rst)
    begin
      kbd_data_line_prev_q <= `KMW_LINE_IDLE;
      mouse_data_line_prev_q <= `KMW_LINE_IDLE;
    end
    else
    begin
      kbd_data_line_prev_q <= kbd_data_line_s;
      mouse_data_line_prev_q <= mouse_data_line_s;
    end
  end

  wire kbd_data_line_fall = kbd_data_line_prev_q && !kbd_data_line_s;
  wire mouse_data_line_fall = mouse_data_line_prev_q && !mouse_data_line_s;
  // core irqs count only with main power and no isolation
  wire kirq_evt = kirq_q && pwr_s && !k_iso_q;
  wire mirq_evt = mirq_q && pwr_s && !m_iso_q;
  wire kset = kbd_data_line_fall || kirq_evt;
  wire mset = mouse_data_line_fall || mirq_evt;
  wire kclr = wr_sts && bus.cfg_wdata[`KMW_BIT_STS_KBD];
  wire mclr = wr_sts && bus.cfg_wdata[`KMW_BIT_STS_MOUSE];

  // status kept on standby; a set wins over a clear
  always_ff @(posedge clk)
  begin
    if (stby_rst)
    begin
      sts_kbd_q <= 1'b0;
      sts_mouse_q <= 1'b0;
    end
    else
    begin
      sts_kbd_q <= kset || (sts_kbd_q && !kclr);
      sts_mouse_q <= mset || (sts_mouse_q && !mclr);
    end
  end

  // ==========================================================
  // wake output
  logic wake_q;
  wire glob_en = wake_en_q[`KMW_BIT_EN_GLOBAL];
  wire wake_d = glob_en &&
                ((sts_kbd_q && wake_en_q[`KMW_BIT_STS_KBD]) ||
                 (sts_mouse_q && wake_en_q[`KMW_BIT_STS_MOUSE]));

  always_ff @(posedge clk)
  begin
    if (stby_rst)
      wake_q <= 1'b0;
    else
      wake_q <= wake_d;
  end

  assign bus.wake_event_out = wake_q;

  // ==========================================================
  // read path; unmapped offsets read zero
  kmw_byte_t sts_byte;
  kmw_byte_t opt_byte;

  always_comb
  begin
    sts_byte = `KMW_RST_BYTE;
    sts_byte[`KMW_BIT_STS_KBD] = sts_kbd_q;
    sts_byte[`KMW_BIT_STS_MOUSE] = sts_mouse_q;
    opt_byte = option_lo_q;
    opt_byte[`KMW_BIT_K_ISO] = k_iso_q;
    opt_byte[`KMW_BIT_M_ISO] = m_iso_q;
  end

  wire [7:0] rd_mux =
    (bus.cfg_addr == `KMW_OFS_CORE_RST) ? core_rst_q :
    (bus.cfg_addr == `KMW_OFS_OPTION) ? opt_byte :
    (bus.cfg_addr == `KMW_OFS_WAKE_STS) ? sts_byte :
    (bus.cfg_addr == `KMW_OFS_WAKE_EN) ? wake_en_q : `KMW_RST_BYTE;

  // read data lands one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata_q <= `KMW_RST_BYTE;
    else if (bus.cfg_rd)
      rdata_q <= rd_mux;
  end

  assign bus.cfg_rdata = rdata_q;

endmodule // kmw_dev

// ===== kmw_params.svh
`ifndef KMW_PARAMS_SVH
`define KMW_PARAMS_SVH

// ==========================================================
// register offsets
`define KMW_OFS_CORE_RST 8'h2c
`define KMW_OFS_OPTION 8'hf0
`define KMW_OFS_WAKE_STS 8'hf1
`define KMW_OFS_WAKE_EN 8'hf2

// ==========================================================
// field positions
`define KMW_BIT_CORE_RST 6
`define KMW_BIT_M_ISO 6
`define KMW_BIT_K_ISO 5
`define KMW_BIT_MOUSE_IRQ_LATCH_SEL 4
`define KMW_BIT_KBD_IRQ_LATCH_SEL 3
`define KMW_BIT_STS_MOUSE 4
`define KMW_BIT_STS_KBD 3
`define KMW_BIT_EN_GLOBAL 0

// ==========================================================
// values
`define KMW_RST_BYTE 8'h00
`define KMW_CORE_RST_ON 8'h40
`define KMW_CORE_RST_OFF 8'h00
`define KMW_STS_BOTH 8'h18
`define KMW_EN_GLOBAL_ONLY 8'h01
`define KMW_ISO_MASK 8'h60
`define KMW_LINE_IDLE 1'b1

`endif

// ===== kmw_pkg.sv
package kmw_pkg;

  typedef logic [7:0] kmw_byte_t;

  // host sequencer states
  typedef enum logic [2:0] {
    KMW_IDLE = 3'b000,
    KMW_PUP_CLR = 3'b001,
    KMW_SLP_RD = 3'b010,
    KMW_SLP_CAP = 3'b011,
    KMW_SLP_DIS = 3'b100,
    KMW_WK_RST = 3'b101,
    KMW_WK_HOLD = 3'b110,
    KMW_WK_REL = 3'b111
  } kmw_state_e;

endpackage

// ===== kmw_cfg_if.sv
`timescale 1ns/1ns
interface kmw_cfg_if;
  logic cfg_wr;
  logic cfg_rd;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic kbd_irq;
  logic mouse_irq;
  logic wake_event_out;

  modport dev (
    input cfg_wr,
    input cfg_rd,
    input cfg_addr,
    input cfg_wdata,
    output cfg_rdata,
    output kbd_irq,
    output mouse_irq,
    output wake_event_out
  );

  modport host (
    output cfg_wr,
    output cfg_rd,
    output cfg_addr,
    output cfg_wdata,
    input cfg_rdata,
    input kbd_irq,
    input mouse_irq,
    input wake_event_out
  );
endinterface

// ===== kmw_host.sv
`timescale 1ns/1ns
`include "kmw_params.svh"

module kmw_host
  import kmw_pkg::*;
#(
  parameter int RST_HOLD = 4
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_up_done,
  input wire logic deep_sleep_req,
  input wire logic wake_req,
  input wire logic user_wr,
  input wire logic [7:0] user_addr,
  input wire logic [7:0] user_wdata,
  output logic busy,
  output logic iso_seen,
  kmw_cfg_if.host bus
);

  // ==========================================================
  // sequencer
  kmw_state_e state_q;
  kmw_state_e state_d;
  logic iso_q;
  logic [7:0] hold_q;

  wire hold_done = hold_q == 8'(RST_HOLD - 1);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      KMW_IDLE:
        if (power_up_done)
          state_d = KMW_PUP_CLR;
        else if (deep_sleep_req)
          state_d = KMW_SLP_RD;
        else if (wake_req && iso_q)
          state_d = KMW_WK_RST;
      KMW_PUP_CLR: state_d = KMW_IDLE;
      KMW_SLP_RD: state_d = KMW_SLP_CAP;
      KMW_SLP_CAP: state_d = KMW_SLP_DIS;
      KMW_SLP_DIS: state_d = KMW_IDLE;
      KMW_WK_RST: state_d = KMW_WK_HOLD;
      KMW_WK_HOLD:
        if (hold_done)
          state_d = KMW_WK_REL;
      KMW_WK_REL: state_d = KMW_IDLE;
    endcase
  end

  // iso bits are captured while going down, reused on wake
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= KMW_IDLE;
      iso_q <= 1'b0;
      hold_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == KMW_SLP_CAP)
        iso_q <= |(bus.cfg_rdata & `KMW_ISO_MASK);
      else if (state_q == KMW_WK_REL)
        iso_q <= 1'b0;
      hold_q <= (state_q == KMW_WK_HOLD) ? hold_q + 8'h01 : 8'h00;
    end
  end

  // ==========================================================
  // bus drive; user writes pass only while idle
  wire idle = state_q == KMW_IDLE;

  assign busy = !idle;
  assign iso_seen = iso_q;
  assign bus.cfg_rd = state_q == KMW_SLP_RD;
  assign bus.cfg_wr = (idle && user_wr) || state_q == KMW_PUP_CLR ||
                      state_q == KMW_SLP_DIS || state_q == KMW_WK_RST ||
                      state_q == KMW_WK_REL;
  assign bus.cfg_addr =
    (state_q == KMW_PUP_CLR) ? `KMW_OFS_WAKE_STS :
    (state_q == KMW_SLP_RD || state_q == KMW_SLP_CAP) ? `KMW_OFS_OPTION :
    (state_q == KMW_SLP_DIS) ? `KMW_OFS_WAKE_EN :
    (state_q == KMW_WK_RST || state_q == KMW_WK_HOLD ||
     state_q == KMW_WK_REL) ? `KMW_OFS_CORE_RST : user_addr;
  assign bus.cfg_wdata =
    (state_q == KMW_PUP_CLR) ? `KMW_STS_BOTH :
    (state_q == KMW_SLP_DIS) ? `KMW_EN_GLOBAL_ONLY :
    (state_q == KMW_WK_RST) ? `KMW_CORE_RST_ON :
    (state_q == KMW_WK_REL) ? `KMW_CORE_RST_OFF :
    user_wdata;

endmodule // kmw_host

// ===== kmw_props.sv
`timescale 1ns/1ns
module kmw_props #(
  parameter int RST_HOLD = 4
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic stby_rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic wake_event_out
);
  localparam int HOLD_LO = RST_HOLD;
  localparam int HOLD_HI = 40;
  logic [7:0] opt_q;
  logic [1:0] iso_q;
  logic [7:0] en_q;
  wire w_opt = cfg_wr && cfg_addr == 8'hf0;
  wire w_en = cfg_wr && cfg_addr == 8'hf2;
  wire w_rst = cfg_wr && cfg_addr == 8'h2c;
  wire en_ok = en_q[0] && (en_q[3] || en_q[4]);
  wire [7:0] opt_exp = {opt_q[7], iso_q, opt_q[4:0]};

  // ==========================================================
  // shadow registers
  // iso and enables sit on standby power: only stby_rst clears them
  always_ff @(posedge clk)
    if (sys_rst)
      opt_q <= 8'h00;
    else if (w_opt)
      opt_q <= cfg_wdata;
  always_ff @(posedge clk)
    if (stby_rst)
      iso_q <= 2'h0;
    else if (w_opt)
      iso_q <= cfg_wdata[6:5];
  always_ff @(posedge clk)
    if (stby_rst)
      en_q <= 8'h00;
    else if (w_en)
      en_q <= cfg_wdata;

  // ==========================================================
  // properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst || stby_rst);

  a_opt_readback: assert property (
    cfg_rd && cfg_addr == 8'hf0 |=> cfg_rdata == opt_exp)
    else $error("option readback wrong");
  a_rdata_stands: assert property (
    !$past(cfg_rd) |-> $stable(cfg_rdata))
    else $error("read data moved without read");
  a_wake_gated: assert property (
    wake_event_out |-> $past(en_ok))
    else $error("wake without enables");
  a_wake_drops: assert property (
    $fell(en_q[0]) |=> !wake_event_out)
    else $error("wake kept after global enable off");
  a_core_rst_value: assert property (
    w_rst |-> cfg_wdata == 8'h40 || cfg_wdata == 8'h00)
    else $error("core reset register got stray bits");
  a_core_rst_pair: assert property (
    w_rst && cfg_wdata == 8'h40 |-> ##[HOLD_LO:HOLD_HI]
    (w_rst && cfg_wdata == 8'h00))
    else $error("core reset not released in time");
  a_sleep_disable: assert property (
    cfg_rd && cfg_addr == 8'hf0 |-> ##2
    (w_en && cfg_wdata == 8'h01))
    else $error("enables not cleared before sleep");
  a_status_clear: assert property (
    cfg_wr && cfg_addr == 8'hf1 |-> cfg_wdata == 8'h18)
    else $error("status clear value wrong");
endmodule // kmw_props

// ===== test_kbd_mouse_irq_latch_wake.sv
`timescale 1ns/1ns
module test_kbd_mouse_irq_latch_wake;
  logic clk = 0, sys_rst = 1, stby_rst = 1, pwr = 1;
  logic kd = 0, kc = 1, md = 1, mc = 1, kr = 0, mr = 0, ko = 0, mo = 0;
  logic pud = 0, dsr = 0, wkr = 0, uw = 0, busy, iso_seen;
  logic [7:0] ua = 8'h00, ud = 8'h00;
  logic ckd, ckc, cmd, cmc, crst;
  int fails = 0, samples_checked = 0, cyc = 0;

  // ==========================================================
  // the two ends joined over the interface
  kmw_cfg_if bus ();
  kmw_dev kmw_dev_i (.clk(clk), .sys_rst(sys_rst), .stby_rst(stby_rst),
    .main_pwr_ok(pwr), .kbd_data_line(kd), .kbd_clock_line(kc),
    .mouse_data_line(md), .mouse_clock_line(mc), .core_kbd_irq_raw(kr),
    .core_mouse_irq_raw(mr), .core_kbd_obuf_read(ko),
    .core_mouse_obuf_read(mo), .core_kbd_data(ckd), .core_kbd_clock(ckc),
    .core_mouse_data(cmd), .core_mouse_clock(cmc), .core_reset(crst),
    .bus(bus.dev));
  kmw_host #(.RST_HOLD(4)) kmw_host_i (.clk(clk), .sys_rst(sys_rst),
    .power_up_done(pud), .deep_sleep_req(dsr), .wake_req(wkr),
    .user_wr(uw), .user_addr(ua), .user_wdata(ud), .busy(busy),
    .iso_seen(iso_seen), .bus(bus.host));
  kmw_props #(.RST_HOLD(4)) kmw_props_i (.clk(clk), .sys_rst(sys_rst),
    .stby_rst(stby_rst), .cfg_wr(bus.cfg_wr), .cfg_rd(bus.cfg_rd),
    .cfg_addr(bus.cfg_addr), .cfg_wdata(bus.cfg_wdata),
    .cfg_rdata(bus.cfg_rdata), .wake_event_out(bus.wake_event_out));

  // ==========================================================
  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      give_verdict();
    end
  end

  // ==========================================================
  // helpers
  task automatic cyc_w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %b expected %b", $time, got, exp);
    end
  endtask
  // host is idle whenever the bench calls this
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    uw <= 1'b1;
    ua <= a;
    ud <= d;
    @(posedge clk);
    uw <= 1'b0;
    cyc_w(2);
  endtask
  task automatic obuf_rd();
    ko <= 1'b1;
    mo <= 1'b1;
    @(posedge clk);
    ko <= 1'b0;
    mo <= 1'b0;
    cyc_w(3);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // keyboard held its data line low across power-up
  task automatic t_power_up();
    cyc_w(6);
    chk(bus.wake_event_out, 1'b0);
    wr(8'hf2, 8'h19);
    cyc_w(3);
    chk(bus.wake_event_out, 1'b1);
    kd <= 1'b1;
    pud <= 1'b1;
    @(posedge clk);
    pud <= 1'b0;
    cyc_w(5);
    chk(bus.wake_event_out, 1'b0);
  endtask
  // five enable mixes against a data-line edge
  task automatic t_wake_en();
    logic [7:0] en [5] = '{8'h01, 8'h08, 8'h09, 8'h10, 8'h11};
    for (int i = 0; i < 5; i++)
    begin
      wr(8'hf2, en[i]);
      wr(8'hf1, 8'h18);
      if (i < 3)
        kd <= 1'b0;
      else
        md <= 1'b0;
      cyc_w(6);
      chk(bus.wake_event_out, en[i][0] & (en[i][3] | en[i][4]));
      kd <= 1'b1;
      md <= 1'b1;
      cyc_w(4);
    end
  endtask
  task automatic t_irq();
    for (int s = 0; s < 2; s++)
    begin
      wr(8'hf0, s[0] ? 8'h18 : 8'h00);
      kr <= 1'b1;
      mr <= 1'b1;
      @(posedge clk);
      kr <= 1'b0;
      mr <= 1'b0;
      cyc_w(4);
      chk(bus.kbd_irq, s[0]);
      chk(bus.mouse_irq, s[0]);
      kr <= 1'b1;
      mr <= 1'b1;
      cyc_w(4);
      chk(bus.kbd_irq, 1'b1);
      chk(bus.mouse_irq, 1'b1);
      obuf_rd();
      chk(bus.kbd_irq, 1'b0);
      chk(bus.mouse_irq, 1'b0);
      kr <= 1'b0;
      mr <= 1'b0;
    end
  endtask
  // irq wakes need main power, data-line wakes do not
  task automatic t_main_pwr();
    wr(8'hf2, 8'h19);
    wr(8'hf0, 8'h08);
    pwr <= 1'b0;
    wr(8'hf1, 8'h18);
    kr <= 1'b1;
    @(posedge clk);
    kr <= 1'b0;
    cyc_w(6);
    chk(bus.wake_event_out, 1'b0);
    pwr <= 1'b1;
    cyc_w(6);
    chk(bus.wake_event_out, 1'b1);
    obuf_rd();
    pwr <= 1'b0;
    wr(8'hf1, 8'h18);
    chk(bus.wake_event_out, 1'b0);
    kd <= 1'b0;
    cyc_w(6);
    chk(bus.wake_event_out, 1'b1);
    pwr <= 1'b1;
  endtask
  task automatic t_iso();
    wr(8'hf0, 8'h60);
    wr(8'hf1, 8'h18);
    kd <= 1'b1;
    cyc_w(4);
    kd <= 1'b0;
    kc <= 1'b0;
    md <= 1'b0;
    mc <= 1'b0;
    cyc_w(6);
    chk(ckd, 1'b1);
    chk(ckc, 1'b1);
    chk(cmd, 1'b1);
    chk(cmc, 1'b1);
    chk(bus.wake_event_out, 1'b1);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    cyc_w(4);
    chk(ckd, 1'b1);
    chk(bus.wake_event_out, 1'b1);
    wr(8'hf1, 8'h18);
    kr <= 1'b1;
    cyc_w(6);
    chk(bus.wake_event_out, 1'b0);
    kr <= 1'b0;
    obuf_rd();
    wr(8'hf0, 8'h00);
    cyc_w(4);
    chk(ckd, 1'b0);
    chk(cmc, 1'b0);
    wr(8'hf0, 8'h60);
    stby_rst <= 1'b1;
    @(posedge clk);
    stby_rst <= 1'b0;
    cyc_w(4);
    chk(ckd, 1'b0);
    chk(bus.wake_event_out, 1'b0);
    kd <= 1'b1;
    kc <= 1'b1;
    md <= 1'b1;
    mc <= 1'b1;
    cyc_w(4);
  endtask
  // reset bit holds until written back, then the sleep and wake walk
  task automatic t_core_rst();
    wr(8'h2c, 8'h40);
    cyc_w(20);
    chk(crst, 1'b1);
    wr(8'h2c, 8'h00);
    chk(crst, 1'b0);
    wr(8'hf0, 8'h40);
    dsr <= 1'b1;
    @(posedge clk);
    dsr <= 1'b0;
    cyc_w(6);
    chk(iso_seen, 1'b1);
    wkr <= 1'b1;
    @(posedge clk);
    wkr <= 1'b0;
    cyc_w(3);
    chk(crst, 1'b1);
    chk(busy, 1'b1);
    cyc_w(8);
    chk(crst, 1'b0);
    chk(busy, 1'b0);
    chk(iso_seen, 1'b0);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    cyc_w(3);
    sys_rst <= 1'b0;
    stby_rst <= 1'b0;
    t_power_up();
    t_wake_en();
    t_irq();
    t_main_pwr();
    t_iso();
    t_core_rst();
    give_verdict();
  end
endmodule // test_kbd_mouse_irq_latch_wake
